/* wdc_watchdog_ctrl.sv */
/*
 * watchdog control register, reset-cause flags, timed-access protection,
 * boot-region select and watchdog interrupt priority.
 * assumes: register writes are single-cycle strobes synchronous to CORE_CLK;
 * reset causes are one-cycle pulses from the chip reset controller, with
 * RST a synchronous active-high reset that returns only the unlock sequencer, the outputs and RD_DATA.
 */
// Overview of operation
// [R1] power-on flag set at power-up, software-only clear
// [R2] timeout sets interrupt flag until software clears
// [R3] reset flag set by enabled watchdog reset
// [R4] reset enable gates watchdog reset and flag
// [R5] restart write clears count, bit self-clears
// [R6] external reset loads pattern 0x0x0xx0
// [R7] watchdog reset sets flag, others kept
// [R8] power reset clears flag and enable, sets power-on
// [R9] all readable; protected bits need timed access
// [R10] software writes AA then 55 first
// [R11] unprotected bits take ordinary writes
// [R12] boot-select picks loader or application region
// [R13] boot-select register writes need unlock
// [R14] watchdog priority bit at position four
// [R15] protected write only shortly after unlock
`timescale 1ns/1ps
`include "wdc_map.svh"

module wdc_watchdog_ctrl (
    // clock and reset
    input  wire logic                  CORE_CLK,
    input  wire logic                  RST,
    // register access from the core
    input  wire wdc_pkg::wdc_wr_type   REG_WR,
    input  wire logic [7:0]            RD_ADDR,
    output      logic [7:0]            RD_DATA,
    // reset causes from the reset controller
    input  wire wdc_pkg::wdc_cause_type RST_CAUSE,
    // watchdog counter, reset request, irq priority and boot select
    input  wire logic                  WDT_TIMEOUT,
    output      logic                  WDT_CLEAR,
    output      logic                  WDT_RESET_REQ,
    output      logic                  WDT_IRQ_PRIO,
    output      logic                  BOOT_FROM_LOADER
);

    logic [7:0]          ctrl_q;       // control register
    logic [7:0]          ctrl_d;
    logic                boot_q;       // boot-from-loader
    logic                prio_q;       // watchdog irq priority
    wdc_pkg::wdc_key_type key_q;       // unlock sequencer
    logic [3:0]          open_cnt_q;   // cycles left in the unlock window
    logic                ctrl_wr;
    logic                key_wr;
    logic                unlocked;

    assign ctrl_wr  = REG_WR.wr && (REG_WR.addr == `WDC_ADDR_CONTROL);
    assign key_wr   = REG_WR.wr && (REG_WR.addr == `WDC_ADDR_KEY);
    // window is short so stray code cannot reuse an old unlock
    assign unlocked = (key_q == wdc_pkg::KEY_OPEN); // [R15]

    // unlock sequencer: AA then 55 opens a short window
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            key_q      <= wdc_pkg::KEY_IDLE;
            open_cnt_q <= 4'h0;
        end else begin
            case (key_q)
                wdc_pkg::KEY_IDLE: begin
                    if (key_wr && REG_WR.data == `WDC_KEY_FIRST) begin // [R10]
                        key_q <= wdc_pkg::KEY_FIRST;
                    end
                end
                wdc_pkg::KEY_FIRST: begin
                    // any write other than the second key aborts
                    if (key_wr && REG_WR.data == `WDC_KEY_SECOND) begin // [R10]
                        key_q      <= wdc_pkg::KEY_OPEN;
                        open_cnt_q <= `WDC_UNLOCK_CYCLES;
                    end else if (REG_WR.wr) begin
                        key_q <= wdc_pkg::KEY_IDLE;
                    end
                end
                wdc_pkg::KEY_OPEN: begin
                    // any write other than to the key register, or window expiry, closes it
                    if ((REG_WR.wr && !key_wr) || open_cnt_q == 4'h1) begin // [R15]
                        key_q      <= wdc_pkg::KEY_IDLE;
                        open_cnt_q <= 4'h0;
                    end else begin
                        open_cnt_q <= open_cnt_q - 4'h1;
                    end
                end
                default: begin
                    key_q <= wdc_pkg::KEY_IDLE;
                end
            endcase
        end
    end

    // control register next value; reset causes take priority over writes
    always_comb begin
        ctrl_d = ctrl_q;
        ctrl_d[`WDC_BIT_RESTART] = 1'b0; // [R5]
        if (ctrl_wr) begin
            // unprotected bits always, protected only when unlocked
            ctrl_d = (ctrl_q & `WDC_PROT_MASK) | (REG_WR.data & ~`WDC_PROT_MASK); // [R11]
            // a locked write must not replay a restart still held in ctrl_q
            ctrl_d[`WDC_BIT_RESTART] = 1'b0; // [R5]
            if (unlocked) begin
                ctrl_d = REG_WR.data; // [R9]
            end
        end
        // hardware set wins over a same-cycle software clear
        if (WDT_TIMEOUT) begin
            ctrl_d[`WDC_BIT_IRQ_FLAG] = 1'b1; // [R2]
        end
        if (RST_CAUSE.watchdog && ctrl_q[`WDC_BIT_RST_EN]) begin
            ctrl_d = ctrl_q; // [R7]
            ctrl_d[`WDC_BIT_RST_FLAG] = 1'b1; // [R3]
        end
        if (RST_CAUSE.external) begin
            ctrl_d = ctrl_q & ~`WDC_EXT_CLR_MASK; // [R6]
        end
        if (RST_CAUSE.power_on) begin
            // power-up is a full reset, so every stored bit starts defined
            ctrl_d = ctrl_q & ~(`WDC_EXT_CLR_MASK | `WDC_UNIMPL_CTRL); // [R8]
            ctrl_d[`WDC_BIT_RST_FLAG] = 1'b0; // [R8]
            ctrl_d[`WDC_BIT_RST_EN]   = 1'b0; // [R8]
            ctrl_d[`WDC_BIT_PWR_ON]   = 1'b1; // [R1]
        end
    end

    // control register store; power-on flag cleared only by software
    always_ff @(posedge CORE_CLK) begin
        ctrl_q <= ctrl_d; // [R1]
    end

    // boot-select and priority registers
    always_ff @(posedge CORE_CLK) begin
        if (RST_CAUSE.power_on) begin
            boot_q <= 1'b0;
            prio_q <= 1'b0;
        end else begin
            if (REG_WR.wr && REG_WR.addr == `WDC_ADDR_BOOT_SEL && unlocked) begin
                boot_q <= REG_WR.data[`WDC_BIT_BOOT_LOADER]; // [R13]
            end
            if (REG_WR.wr && REG_WR.addr == `WDC_ADDR_EXT_PRIO) begin
                prio_q <= REG_WR.data[`WDC_BIT_WDT_PRIO]; // [R14]
            end
        end
    end

    // outputs to the counter, reset controller and core
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            WDT_CLEAR        <= 1'b0;
            WDT_RESET_REQ    <= 1'b0;
            WDT_IRQ_PRIO     <= 1'b0;
            BOOT_FROM_LOADER <= 1'b0;
        end else begin
            WDT_CLEAR        <= ctrl_d[`WDC_BIT_RESTART]; // [R5]
            WDT_RESET_REQ    <= WDT_TIMEOUT && ctrl_q[`WDC_BIT_RST_EN]; // [R4]
            WDT_IRQ_PRIO     <= prio_q; // [R14]
            BOOT_FROM_LOADER <= boot_q; // [R12]
        end
    end

    // read mux; unimplemented bits read high
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            RD_DATA <= 8'h00;
        end else begin
            case (RD_ADDR)
                `WDC_ADDR_CONTROL:  RD_DATA <= ctrl_q | `WDC_UNIMPL_CTRL; // [R9]
                `WDC_ADDR_BOOT_SEL: RD_DATA <= {7'h7F, boot_q};
                `WDC_ADDR_EXT_PRIO: RD_DATA <= `WDC_UNIMPL_PRIO | {3'h0, prio_q, 4'h0};
                default:            RD_DATA <= 8'hFF;
            endcase
        end
    end

    // assertions
    property p_timeout_flag;
        @(posedge CORE_CLK) disable iff (RST)
        WDT_TIMEOUT && !RST_CAUSE.external && !RST_CAUSE.power_on |=> ctrl_q[`WDC_BIT_IRQ_FLAG];
    endproperty
    a_timeout_sets_flag: assert property (p_timeout_flag) else $error("timeout did not set irq flag"); // [R2]

    a_restart_self_clear: assert property (@(posedge CORE_CLK) disable iff (RST)
        ctrl_q[`WDC_BIT_RESTART] |=> !ctrl_q[`WDC_BIT_RESTART] || $past(ctrl_wr && unlocked))
        else $error("restart bit did not self clear"); // [R5]

    // an accepted restart write must reach the counter as one clear pulse
    a_restart_pulses: assert property (@(posedge CORE_CLK) disable iff (RST) // [R5]
        ctrl_wr && unlocked && REG_WR.data[`WDC_BIT_RESTART] && !RST_CAUSE.watchdog
        && !RST_CAUSE.external && !RST_CAUSE.power_on |=> WDT_CLEAR ##1 !WDT_CLEAR)
        else $error("restart write gave no clear pulse");

    a_reset_needs_enable: assert property (@(posedge CORE_CLK) disable iff (RST)
        WDT_RESET_REQ |-> $past(ctrl_q[`WDC_BIT_RST_EN]) && $past(WDT_TIMEOUT))
        else $error("watchdog reset without enable"); // [R4]

    a_power_on_sets: assert property (@(posedge CORE_CLK)
        RST_CAUSE.power_on |=> ctrl_q[`WDC_BIT_PWR_ON] && !ctrl_q[`WDC_BIT_RST_EN] && !ctrl_q[`WDC_BIT_RST_FLAG])
        else $error("power reset did not load flags"); // [R8]

    a_ext_reset_clears: assert property (@(posedge CORE_CLK)
        RST_CAUSE.external && !RST_CAUSE.power_on |=> (ctrl_q & `WDC_EXT_CLR_MASK) == 8'h00)
        else $error("external reset left defined bits set"); // [R6]

    a_wdt_reset_flag: assert property (@(posedge CORE_CLK)
        RST_CAUSE.watchdog && ctrl_q[`WDC_BIT_RST_EN] && !RST_CAUSE.external && !RST_CAUSE.power_on
        |=> ctrl_q[`WDC_BIT_RST_FLAG])
        else $error("watchdog reset did not set flag"); // [R7]

    a_locked_protect: assert property (@(posedge CORE_CLK) disable iff (RST)
        ctrl_wr && !unlocked && !WDT_TIMEOUT && !RST_CAUSE.power_on && !RST_CAUSE.external
        && !RST_CAUSE.watchdog |=> !ctrl_q[`WDC_BIT_RESTART]
        && {ctrl_q[`WDC_BIT_PWR_ON], ctrl_q[`WDC_BIT_IRQ_FLAG], ctrl_q[`WDC_BIT_RST_EN]}
        == $past({ctrl_q[`WDC_BIT_PWR_ON], ctrl_q[`WDC_BIT_IRQ_FLAG], ctrl_q[`WDC_BIT_RST_EN]}))
        else $error("protected bit changed while locked"); // [R9]

    sequence s_keys;
        key_wr && REG_WR.data == `WDC_KEY_FIRST && key_q == wdc_pkg::KEY_IDLE
        ##1 key_wr && REG_WR.data == `WDC_KEY_SECOND;
    endsequence
    a_unlock_opens: assert property (@(posedge CORE_CLK) disable iff (RST)
        s_keys |=> unlocked)
        else $error("key sequence did not unlock"); // [R15]

    a_boot_locked: assert property (@(posedge CORE_CLK) disable iff (RST)
        !unlocked && !RST_CAUSE.power_on |=> $stable(boot_q))
        else $error("boot select changed while locked"); // [R13]

endmodule : wdc_watchdog_ctrl

/* wdc_map.svh */
/*
 * register map, field positions, reset values and unlock keys for the
 * watchdog control and reset-flag block.
 * assumes the core presents special-function-register accesses on an 8-bit address.
 */
`ifndef WDC_MAP_SVH
`define WDC_MAP_SVH

// register addresses
`define WDC_ADDR_BOOT_SEL   8'hD7
`define WDC_ADDR_CONTROL    8'hD8
`define WDC_ADDR_KEY        8'hC7
`define WDC_ADDR_EXT_PRIO   8'hF8

// control register field positions
`define WDC_BIT_PWR_ON      6
`define WDC_BIT_IRQ_FLAG    3
`define WDC_BIT_RST_FLAG    2
`define WDC_BIT_RST_EN      1
`define WDC_BIT_RESTART     0

// boot-select and priority field positions
`define WDC_BIT_BOOT_LOADER 0
`define WDC_BIT_WDT_PRIO    4

// protected control bits: power-on, irq flag, reset enable, restart
`define WDC_PROT_MASK       8'h4B
// bits defined as zero after an external reset (pattern 0x0x0xx0)
`define WDC_EXT_CLR_MASK    8'hA9
// unimplemented bits read high
`define WDC_UNIMPL_CTRL     8'hB0
`define WDC_UNIMPL_BOOT     8'hFE
`define WDC_UNIMPL_PRIO     8'hEF

// timed-access keys and window
`define WDC_KEY_FIRST       8'hAA
`define WDC_KEY_SECOND      8'h55
`define WDC_UNLOCK_CYCLES   4'h3

`endif

/* wdc_pkg.sv */
/*
 * types shared by the watchdog control block.
 * assumes wdc_map.svh supplies the numeric constants.
 */
package wdc_pkg;

    // register write request from the core
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] data;
    } wdc_wr_type;

    // reset cause presented by the reset controller
    typedef struct packed {
        logic power_on;
        logic external;
        logic watchdog;
    } wdc_cause_type;

    // timed-access unlock states
    typedef enum logic [2:0] {
        KEY_IDLE  = 3'b001,
        KEY_FIRST = 3'b010,
        KEY_OPEN  = 3'b100
    } wdc_key_type;

endpackage : wdc_pkg

/* testbench.sv */
/*
 * self-checking bench for the watchdog control block: register writes,
 * timed-access unlock, reset-cause pulses and timeout pulses, checked by reads.
 * assumes wdc_map.svh and wdc_pkg are compiled first; no other model is needed.
 */
`timescale 1ns/1ps
`include "wdc_map.svh"

// compare helper: counts every check, reports a mismatch at once
`define CHK(act, exp) begin comparisons++; if ((act) !== (exp)) begin mismatches++; \
    $display("mismatch at %0t: got %h expected %h", $time, act, exp); end end

module testbench;
    logic                   core_clk;    // 250 MHz core clock
    logic                   rst;         // sync active-high reset
    wdc_pkg::wdc_wr_type    reg_wr;      // write request to the block
    logic [7:0]             rd_addr;     // read address
    logic [7:0]             rd_data;     // registered read data
    wdc_pkg::wdc_cause_type rst_cause;   // reset-cause pulses
    logic                   wdt_timeout; // counter timeout pulse
    logic                   wdt_clear;   // restart pulse out
    logic                   wdt_req;     // reset request out
    logic                   wdt_prio;    // priority level out
    logic                   boot_ld;     // boot region select out
    int                     mismatches;  // failed checks
    int                     comparisons; // checks made
    int                     clr_cnt = 0; // cycles with restart pulse high
    int                     req_cnt = 0; // cycles with reset request high
    int                     c0;          // snapshot of a pulse count
    int                     i;           // loop index

    wdc_watchdog_ctrl wdc_watchdog_ctrl_inst (
        .CORE_CLK         (core_clk),
        .RST              (rst),
        .REG_WR           (reg_wr),
        .RD_ADDR          (rd_addr),
        .RD_DATA          (rd_data),
        .RST_CAUSE        (rst_cause),
        .WDT_TIMEOUT      (wdt_timeout),
        .WDT_CLEAR        (wdt_clear),
        .WDT_RESET_REQ    (wdt_req),
        .WDT_IRQ_PRIO     (wdt_prio),
        .BOOT_FROM_LOADER (boot_ld)
    );

    // clock: 4 ns period
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // pulse counters: a one-cycle pulse adds exactly one
    always @(posedge core_clk) begin
        clr_cnt <= clr_cnt + int'(wdt_clear === 1'b1);
        req_cnt <= req_cnt + int'(wdt_req === 1'b1);
    end

    // write held only for the edge that takes it; the next call replaces it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= '{wr: 1'b1, addr: a, data: d};
    endtask : wr

    // idle cycle, drops the strobe
    task automatic idle();
        @(posedge core_clk);
        reg_wr <= '0;
    endtask : idle

    // read: address set with strobe dropped, data settled two edges later
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_wr  <= '0;
        rd_addr <= a;
        repeat (2) @(posedge core_clk);
        #1;
        `CHK(rd_data, exp)
    endtask : rd

    // one-cycle reset-cause and timeout pulse
    task automatic pulse(input wdc_pkg::wdc_cause_type c, input logic t);
        @(posedge core_clk);
        reg_wr      <= '0;
        rst_cause   <= c;
        wdt_timeout <= t;
        @(posedge core_clk);
        rst_cause   <= '0;
        wdt_timeout <= 1'b0;
    endtask : pulse

    // both keys back to back
    task automatic unlock();
        wr(`WDC_ADDR_KEY, `WDC_KEY_FIRST);
        wr(`WDC_ADDR_KEY, `WDC_KEY_SECOND);
    endtask : unlock

    task automatic print_verdict();
        if (mismatches == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : print_verdict

    // watchdog: whole run is about a hundred cycles
    initial begin
        #20000;
        mismatches++;
        print_verdict();
    end

    initial begin
        rst = 1'b1;
        reg_wr = '0;
        rd_addr = 8'h00;
        // power-up cause held through reset so the registers start defined
        rst_cause = '{power_on: 1'b1, external: 1'b0, watchdog: 1'b0};
        wdt_timeout = 1'b0;
        mismatches = 0;
        comparisons = 0;
        c0 = 0;
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        rst_cause <= '0;
        pulse('{power_on: 1'b1, external: 1'b0, watchdog: 1'b0}, 1'b0);
        rd(`WDC_ADDR_CONTROL, 8'hF0);
        // locked write: only unprotected bits move
        wr(`WDC_ADDR_CONTROL, 8'hFF);
        rd(`WDC_ADDR_CONTROL, 8'hF4);
        wr(`WDC_ADDR_CONTROL, 8'h00);
        rd(`WDC_ADDR_CONTROL, 8'hF0);
        unlock();
        wr(`WDC_ADDR_CONTROL, 8'h42);
        rd(`WDC_ADDR_CONTROL, 8'hF2);
        // timeout with reset enabled
        c0 = req_cnt;
        pulse('0, 1'b1);
        rd(`WDC_ADDR_CONTROL, 8'hFA);
        `CHK(req_cnt - c0, 1)
        pulse('{power_on: 1'b0, external: 1'b0, watchdog: 1'b1}, 1'b0);
        rd(`WDC_ADDR_CONTROL, 8'hFE);
        pulse('{power_on: 1'b0, external: 1'b1, watchdog: 1'b0}, 1'b0);
        rd(`WDC_ADDR_CONTROL, 8'hF6);
        // software clears the power-on flag, power-up sets it again
        unlock();
        wr(`WDC_ADDR_CONTROL, 8'h02);
        rd(`WDC_ADDR_CONTROL, 8'hB2);
        pulse('{power_on: 1'b1, external: 1'b0, watchdog: 1'b0}, 1'b0);
        rd(`WDC_ADDR_CONTROL, 8'hF0);
        // restart: one clear pulse, bit self-clears
        c0 = clr_cnt;
        unlock();
        wr(`WDC_ADDR_CONTROL, 8'h41);
        rd(`WDC_ADDR_CONTROL, 8'hF0);
        `CHK(clr_cnt - c0, 1)
        // timeout and watchdog cause with reset disabled
        c0 = req_cnt;
        pulse('0, 1'b1);
        pulse('{power_on: 1'b0, external: 1'b0, watchdog: 1'b1}, 1'b0);
        rd(`WDC_ADDR_CONTROL, 8'hF8);
        `CHK(req_cnt - c0, 0)
        unlock();
        wr(`WDC_ADDR_CONTROL, 8'h40);
        rd(`WDC_ADDR_CONTROL, 8'hF0);
        // stale unlock and aborted key sequence are both ignored
        unlock();
        for (i = 0; i < 4; i++) idle();
        wr(`WDC_ADDR_CONTROL, 8'h02);
        wr(`WDC_ADDR_KEY, `WDC_KEY_FIRST);
        wr(`WDC_ADDR_EXT_PRIO, 8'h00);
        wr(`WDC_ADDR_KEY, `WDC_KEY_SECOND);
        wr(`WDC_ADDR_CONTROL, 8'h02);
        rd(`WDC_ADDR_CONTROL, 8'hF0);
        // boot select needs the unlock
        wr(`WDC_ADDR_BOOT_SEL, 8'h01);
        rd(`WDC_ADDR_BOOT_SEL, 8'hFE);
        `CHK(boot_ld, 1'b0)
        unlock();
        wr(`WDC_ADDR_BOOT_SEL, 8'h01);
        rd(`WDC_ADDR_BOOT_SEL, 8'hFF);
        `CHK(boot_ld, 1'b1)
        // priority bit four, then an unmapped address
        wr(`WDC_ADDR_EXT_PRIO, 8'h10);
        rd(`WDC_ADDR_EXT_PRIO, 8'hFF);
        `CHK(wdt_prio, 1'b1)
        wr(`WDC_ADDR_EXT_PRIO, 8'h00);
        rd(`WDC_ADDR_EXT_PRIO, 8'hEF);
        `CHK(wdt_prio, 1'b0)
        rd(8'h00, 8'hFF);
        print_verdict();
    end
endmodule : testbench
